/* File: rtl/hfa_pkg.sv */
// Shared constants and types for the hex floating-point arithmetic unit.
package hfa_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_FAULT_ADDR = 4'h4;
  localparam logic [3:0] REG_RESULT_HI = 4'h8;
  localparam logic [3:0] REG_RESULT_LO = 4'hC;

  // Fields of the float status register.
  localparam int BIT_OVER = 1;
  localparam int BIT_UNDER = 2;
  localparam int BIT_INVALID = 3;
  localparam int BIT_RSEL = 8;
  localparam int CODE_LSB = 28;
  localparam logic [3:0] CODE_ZERO_DIV = 4'h0;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_WMASK = 32'hF000_010E;

  // Operand layout: sign, excess-64 exponent, fraction.
  localparam int SIGN_BIT = 63;
  localparam int EXP_MSB = 62;
  localparam int EXP_LSB = 56;
  localparam logic signed [9:0] EXP_BIAS = 10'sh040;
  localparam logic signed [9:0] EXP_MAX = 10'sh07F;
  localparam logic signed [9:0] EXP_ONE = 10'sh001;

  // Kept bits of the 64-bit working fraction (fraction plus guard digits).
  localparam logic [6:0] KEEP_S_TRN = 7'h1C;
  localparam logic [6:0] KEEP_S_ROUND = 7'h20;
  localparam logic [6:0] KEEP_D_TRN = 7'h3C;
  localparam logic [6:0] KEEP_D_ROUND = 7'h40;
  // Alignment shift, in hex digits, that pushes every significant digit out.
  localparam logic [9:0] LIM_S_TRN = 10'h007;
  localparam logic [9:0] LIM_S_ROUND = 10'h008;
  localparam logic [9:0] LIM_D_TRN = 10'h00F;
  localparam logic [9:0] LIM_D_ROUND = 10'h010;

  localparam logic [55:0] FRAC_ONE_D = 56'h10_0000_0000_0000;
  localparam logic [55:0] FRAC_ONE_S = 56'h00_0000_0010_0000;
  localparam logic [7:0] GUARD_HALF = 8'h80;
  localparam logic [6:0] DIV_STEPS = 7'h40;

  typedef enum logic [1:0] {
    OP_ADD = 2'b00,
    OP_SUB = 2'b01,
    OP_MUL = 2'b10,
    OP_DIV = 2'b11
  } hfa_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALIGN = 3'b001,
    ST_ADD = 3'b010,
    ST_MUL = 3'b011,
    ST_PREDIV = 3'b100,
    ST_DIVWAIT = 3'b101,
    ST_NORM = 3'b110,
    ST_ROUND = 3'b111
  } hfa_state_type;
endpackage

/* File: rtl/hfa_frac_divider.sv */
// Restoring fraction divider, one quotient bit per clock.
`timescale 1ns/1ps
`default_nettype none
module hfa_frac_divider (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [63:0] dividend,
  input wire logic [63:0] divisor,
  output logic busy,
  output logic [63:0] quotient
);
  logic [64:0] rem_q;
  logic [63:0] div_q;
  logic [6:0] count_q;
  logic [64:0] shifted;
  logic fits;

  // The dividend is below the divisor, so the quotient is a pure fraction.
  assign shifted = {rem_q[63:0], 1'b0};
  assign fits = shifted >= {1'b0, div_q};
  assign busy = count_q != 7'h00;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rem_q <= 65'h0_0000_0000_0000_0000;
      div_q <= 64'h0000_0000_0000_0000;
      quotient <= 64'h0000_0000_0000_0000;
      count_q <= 7'h00;
    end else if (start) begin
      rem_q <= {1'b0, dividend};
      div_q <= divisor;
      quotient <= 64'h0000_0000_0000_0000;
      count_q <= hfa_pkg::DIV_STEPS;
    end else if (busy) begin
      rem_q <= fits ? shifted - {1'b0, div_q} : shifted;
      quotient <= {quotient[62:0], fits};
      count_q <= count_q - 7'h01;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/hfa_arith_unit.sv */
// Hex floating-point add, subtract, multiply and divide unit with status registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: Shift smaller-exponent fraction right per digit.
// RQ2: Full shift-out gives larger operand plus zero.
// RQ3: Normalize left per digit, exponent minus one.
// RQ4: Normalization shifts zeros into guard digits.
// RQ5: Rounding off: drop the guard digit.
// RQ6: Guards up to 7F: fraction unchanged.
// RQ7: Guards exactly 80: add fraction LSB.
// RQ8: Guards 81 to FF: add one.
// RQ9: Rounding carry: top digit one, exponent up.
// RQ10: Flag exponent overflow or underflow after store.
// RQ11: Algebraic sign; sum carry shifts right.
// RQ12: Carry exponent overflow sets flag, terminates.
// RQ13: Zero sum stores true zero.
// RQ14: Subtract adds negated source; source untouched.
// RQ15: Multiply fractions, exponents summed minus 64.
// RQ16: Zero divisor: invalid flag, code, address.
// RQ17: Dividend not smaller: shift right, exponent up.
// RQ18: Divide fractions, exponent difference plus 64.
// RQ19: Rounding select picks one or two guards.
// RQ20: Sign, excess-64 exponent, fraction operands.
// RQ21: Single uses upper word, clears lower.
// RQ22: Start pulse in, completion pulse out.
module hfa_arith_unit (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [1:0] opCode,
  input wire logic isDouble,
  input wire logic [63:0] dstOperand,
  input wire logic [63:0] srcOperand,
  input wire logic [31:0] instrAddr,
  output logic busy,
  output logic done,
  output logic resultWrite,
  output logic [63:0] result,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  hfa_pkg::hfa_state_type state_q;
  logic doneQ;
  logic [67:0] manA_q;
  logic [67:0] manB_q;
  logic signed [9:0] expA_q;
  logic signed [9:0] expB_q;
  logic signA_q;
  logic signB_q;
  logic isDbl_q;
  logic rsel_q;
  logic evOver_q;
  logic evUnder_q;
  logic evInvalid_q;
  logic divStart_q;
  logic [31:0] status_q;
  logic [31:0] faultAddr_q;
  logic ack_q;
  logic [67:0] mask;
  logic [9:0] absDiff;
  logic [9:0] limit;
  logic [67:0] sumMan;
  logic sumSign;
  logic [111:0] product;
  logic divBusy;
  logic [63:0] quotient;
  logic [55:0] fracV;
  logic [7:0] guardV;
  logic incV;
  logic [56:0] sumV;
  logic fracCarry;
  logic [55:0] finFrac;
  logic signed [9:0] finExp;
  logic [63:0] dstX;
  logic [63:0] srcX;

  // Fraction bits plus guard digits that survive any shift.
  function automatic logic [67:0] keepMask(input logic dbl, input logic rs);
    logic [6:0] kb;
    kb = dbl ? (rs ? hfa_pkg::KEEP_D_ROUND : hfa_pkg::KEEP_D_TRN)
             : (rs ? hfa_pkg::KEEP_S_ROUND : hfa_pkg::KEEP_S_TRN);
    return {4'hF, ~(64'hFFFF_FFFF_FFFF_FFFF >> kb)};
  endfunction
  // Working fraction: carry digit, then the fraction, then the guard byte.
  function automatic logic [67:0] unpackMan(input logic [63:0] opnd);
    return {4'h0, opnd[hfa_pkg::EXP_LSB-1:0], 8'h00};
  endfunction
  function automatic logic signed [9:0] unpackExp(input logic [63:0] opnd);
    return signed'({3'b000, opnd[hfa_pkg::EXP_MSB:hfa_pkg::EXP_LSB]});
  endfunction

  assign mask = keepMask(isDbl_q, rsel_q); // [RQ19]
  assign limit = isDbl_q ? (rsel_q ? hfa_pkg::LIM_D_ROUND : hfa_pkg::LIM_D_TRN)
                         : (rsel_q ? hfa_pkg::LIM_S_ROUND : hfa_pkg::LIM_S_TRN);
  assign absDiff = (expA_q >= expB_q) ? 10'(expA_q - expB_q) : 10'(expB_q - expA_q); // [RQ1]
  // The single word lives in the upper half; its lower half is ignored.
  assign dstX = isDouble ? dstOperand : {dstOperand[63:32], 32'h0000_0000}; // [RQ21]
  assign srcX = isDouble ? srcOperand : {srcOperand[63:32], 32'h0000_0000}; // [RQ21]

  // Like signs add magnitudes; unlike signs subtract the smaller from the larger.
  always_comb begin
    if (signA_q == signB_q) begin
      sumMan = manA_q + manB_q;
      sumSign = signA_q; // [RQ11]
    end else if (manA_q >= manB_q) begin
      sumMan = manA_q - manB_q;
      sumSign = signA_q; // [RQ11]
    end else begin
      sumMan = manB_q - manA_q;
      sumSign = signB_q; // [RQ11]
    end
  end
  assign product = manA_q[63:8] * manB_q[63:8]; // [RQ15]
  hfa_frac_divider hfa_frac_divider_i (.sys_clk(sys_clk), .nrst(nrst), .start(divStart_q),
    .dividend(manA_q[63:0]), .divisor(manB_q[63:0]), .busy(divBusy), .quotient(quotient));

  // Rounding on the normalized fraction; guard byte sits right below it.
  always_comb begin
    fracV = isDbl_q ? manA_q[63:8] : {32'h0000_0000, manA_q[63:40]};
    guardV = isDbl_q ? manA_q[7:0] : manA_q[39:32];
    // Without rounding the guard is simply dropped.
    incV = 1'b0; // [RQ5] [RQ6]
    if (rsel_q && guardV > hfa_pkg::GUARD_HALF) begin
      incV = 1'b1; // [RQ8]
    end else if (rsel_q && guardV == hfa_pkg::GUARD_HALF) begin
      incV = fracV[0]; // [RQ7]
    end
    sumV = {1'b0, fracV} + {56'h00_0000_0000_0000, incV};
    fracCarry = isDbl_q ? sumV[56] : sumV[24];
    finFrac = sumV[55:0];
    finExp = expA_q;
    if (fracCarry) begin
      finFrac = isDbl_q ? hfa_pkg::FRAC_ONE_D : hfa_pkg::FRAC_ONE_S; // [RQ9]
      finExp = expA_q + hfa_pkg::EXP_ONE; // [RQ9]
    end
  end

  // Sequencer of the arithmetic steps.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= hfa_pkg::ST_IDLE;
      doneQ <= 1'b0;
      resultWrite <= 1'b0;
      result <= 64'h0000_0000_0000_0000;
      manA_q <= 68'h0_0000_0000_0000_0000;
      manB_q <= 68'h0_0000_0000_0000_0000;
      expA_q <= 10'sh000;
      expB_q <= 10'sh000;
      signA_q <= 1'b0;
      signB_q <= 1'b0;
      isDbl_q <= 1'b0;
      rsel_q <= 1'b0;
      evOver_q <= 1'b0;
      evUnder_q <= 1'b0;
      evInvalid_q <= 1'b0;
      divStart_q <= 1'b0;
    end else begin
      doneQ <= 1'b0;
      divStart_q <= 1'b0;
      unique case (state_q)
        hfa_pkg::ST_IDLE: begin
          resultWrite <= 1'b0;
          if (start) begin // [RQ22]
            isDbl_q <= isDouble;
            rsel_q <= status_q[hfa_pkg::BIT_RSEL]; // [RQ19]
            evOver_q <= 1'b0;
            evUnder_q <= 1'b0;
            evInvalid_q <= 1'b0;
            manA_q <= unpackMan(dstX); // [RQ20]
            manB_q <= unpackMan(srcX); // [RQ20]
            expA_q <= unpackExp(dstX);
            expB_q <= unpackExp(srcX);
            signA_q <= dstX[hfa_pkg::SIGN_BIT];
            // Only the working copy of the source sign flips; the source stays intact.
            signB_q <= srcX[hfa_pkg::SIGN_BIT] ^ (opCode == hfa_pkg::OP_SUB); // [RQ14]
            unique case (hfa_pkg::hfa_op_type'(opCode))
              hfa_pkg::OP_ADD, hfa_pkg::OP_SUB: state_q <= hfa_pkg::ST_ALIGN;
              hfa_pkg::OP_MUL: state_q <= hfa_pkg::ST_MUL;
              hfa_pkg::OP_DIV: state_q <= hfa_pkg::ST_PREDIV;
            endcase
          end
        end
        hfa_pkg::ST_ALIGN: begin
          if (absDiff == 10'h000) begin
            state_q <= hfa_pkg::ST_ADD;
          end else if (absDiff >= limit) begin
            // Every significant digit would leave: add zero to the larger operand.
            if (expA_q > expB_q) begin
              manB_q <= 68'h0_0000_0000_0000_0000; // [RQ2]
              expB_q <= expA_q;
            end else begin
              manA_q <= 68'h0_0000_0000_0000_0000; // [RQ2]
              expA_q <= expB_q;
            end
            state_q <= hfa_pkg::ST_ADD;
          end else if (expA_q > expB_q) begin
            manB_q <= (manB_q >> 4) & mask; // [RQ1]
            expB_q <= expB_q + hfa_pkg::EXP_ONE;
          end else begin
            manA_q <= (manA_q >> 4) & mask; // [RQ1]
            expA_q <= expA_q + hfa_pkg::EXP_ONE;
          end
        end
        hfa_pkg::ST_ADD: begin
          signA_q <= sumSign;
          if (sumMan[67:64] != 4'h0) begin
            manA_q <= (sumMan >> 4) & mask; // [RQ11]
            expA_q <= expA_q + hfa_pkg::EXP_ONE;
            if (expA_q + hfa_pkg::EXP_ONE > hfa_pkg::EXP_MAX) begin
              evOver_q <= 1'b1; // [RQ12]
              doneQ <= 1'b1;
              state_q <= hfa_pkg::ST_IDLE;
            end else begin
              state_q <= hfa_pkg::ST_NORM;
            end
          end else begin
            manA_q <= sumMan & mask;
            state_q <= hfa_pkg::ST_NORM;
          end
        end
        hfa_pkg::ST_MUL: begin
          signA_q <= signA_q ^ signB_q;
          manA_q <= {4'h0, product[111:48]} & mask; // [RQ15]
          expA_q <= expA_q + expB_q - hfa_pkg::EXP_BIAS; // [RQ15]
          state_q <= hfa_pkg::ST_NORM;
        end
        hfa_pkg::ST_PREDIV: begin
          if (manB_q == 68'h0_0000_0000_0000_0000) begin
            evInvalid_q <= 1'b1; // [RQ16]
            doneQ <= 1'b1;
            state_q <= hfa_pkg::ST_IDLE;
          end else if (manA_q >= manB_q) begin
            manA_q <= manA_q >> 4; // [RQ17]
            expA_q <= expA_q + hfa_pkg::EXP_ONE; // [RQ17]
          end else begin
            divStart_q <= 1'b1;
            state_q <= hfa_pkg::ST_DIVWAIT;
          end
        end
        hfa_pkg::ST_DIVWAIT: begin
          if (!divStart_q && !divBusy) begin
            signA_q <= signA_q ^ signB_q;
            manA_q <= {4'h0, quotient} & mask; // [RQ18]
            expA_q <= expA_q - expB_q + hfa_pkg::EXP_BIAS; // [RQ18]
            state_q <= hfa_pkg::ST_NORM;
          end
        end
        hfa_pkg::ST_NORM: begin
          if ((manA_q & mask) == 68'h0_0000_0000_0000_0000) begin
            result <= 64'h0000_0000_0000_0000; // [RQ13]
            resultWrite <= 1'b1;
            doneQ <= 1'b1;
            state_q <= hfa_pkg::ST_IDLE;
          end else if (manA_q[63:60] == 4'h0) begin
            manA_q <= (manA_q << 4) & mask; // [RQ3] [RQ4]
            expA_q <= expA_q - hfa_pkg::EXP_ONE; // [RQ3]
          end else begin
            state_q <= hfa_pkg::ST_ROUND;
          end
        end
        hfa_pkg::ST_ROUND: begin
          result <= {signA_q, finExp[6:0],
                     isDbl_q ? finFrac : {finFrac[23:0], 32'h0000_0000}}; // [RQ21]
          resultWrite <= 1'b1;
          // The exponent field is meaningless once a range flag is raised.
          evOver_q <= finExp > hfa_pkg::EXP_MAX; // [RQ10]
          evUnder_q <= finExp < 10'sh000; // [RQ10]
          doneQ <= 1'b1;
          state_q <= hfa_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign done = doneQ; // [RQ22]
  assign busy = state_q != hfa_pkg::ST_IDLE;

  // Avalon-MM slave: one wait cycle on every access, write takes effect on the release edge.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      unique case (avs_address)
        hfa_pkg::REG_STATUS: avs_readdata <= status_q;
        hfa_pkg::REG_FAULT_ADDR: avs_readdata <= faultAddr_q;
        hfa_pkg::REG_RESULT_HI: avs_readdata <= result[63:32];
        hfa_pkg::REG_RESULT_LO: avs_readdata <= result[31:0];
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Status flags are sticky; a flag raised by a finishing operation beats a software write.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= hfa_pkg::STATUS_RESET;
    end else begin
      logic [31:0] next;
      logic [31:0] lanes;
      next = status_q;
      lanes = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      if (avs_write && ack_q && avs_address == hfa_pkg::REG_STATUS) begin
        next = (status_q & ~(lanes & hfa_pkg::STATUS_WMASK)) | (avs_writedata & lanes & hfa_pkg::STATUS_WMASK);
      end
      if (doneQ && evOver_q) begin
        next[hfa_pkg::BIT_OVER] = 1'b1; // [RQ10] [RQ12]
      end
      if (doneQ && evUnder_q) begin
        next[hfa_pkg::BIT_UNDER] = 1'b1; // [RQ10]
      end
      if (doneQ && evInvalid_q) begin
        next[hfa_pkg::BIT_INVALID] = 1'b1; // [RQ16]
        next[hfa_pkg::CODE_LSB +: 4] = hfa_pkg::CODE_ZERO_DIV; // [RQ16]
      end
      status_q <= next;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      faultAddr_q <= 32'h0000_0000;
    end else if (start && state_q == hfa_pkg::ST_IDLE && opCode == hfa_pkg::OP_DIV
                 && srcX[hfa_pkg::EXP_LSB-1:0] == 56'h00_0000_0000_0000) begin
      faultAddr_q <= instrAddr; // [RQ16]
    end
  end

  chk_done_pulse: assert property (@(posedge sys_clk) disable iff (!nrst) done |=> !done) // [RQ22]
    else $error("completion pulse lasted more than one cycle");
  chk_align_equal: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == hfa_pkg::ST_ADD |-> expA_q == expB_q) // [RQ1]
    else $error("addition entered with unequal exponents");
  chk_norm_step: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == hfa_pkg::ST_NORM && (manA_q & mask) != 68'h0_0000_0000_0000_0000 && manA_q[63:60] == 4'h0
    |=> expA_q == $past(expA_q) - hfa_pkg::EXP_ONE && manA_q[63:0] == $past(manA_q[59:0]) << 4) // [RQ3]
    else $error("normalization step did not shift one digit");
  chk_round_top: assert property (@(posedge sys_clk) disable iff (!nrst)
    state_q == hfa_pkg::ST_ROUND |-> manA_q[63:60] != 4'h0) // [RQ3]
    else $error("rounding an unnormalized fraction");
  chk_zero_div: assert property (@(posedge sys_clk) disable iff (!nrst)
    start && !busy && opCode == hfa_pkg::OP_DIV && srcX[55:0] == 56'h00_0000_0000_0000
    |=> ##1 done && evInvalid_q && !resultWrite ##1 status_q[hfa_pkg::BIT_INVALID]) // [RQ16]
    else $error("zero divisor not flagged");
  chk_div_order: assert property (@(posedge sys_clk) disable iff (!nrst)
    divStart_q |-> manA_q < manB_q) // [RQ17]
    else $error("divider started with dividend not below divisor");
  chk_single_low: assert property (@(posedge sys_clk) disable iff (!nrst)
    done && resultWrite && !isDbl_q |-> result[31:0] == 32'h0000_0000) // [RQ21]
    else $error("single result left lower word nonzero");
  chk_true_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    done && resultWrite && result[55:0] == 56'h00_0000_0000_0000 |-> result == 64'h0000_0000_0000_0000) // [RQ13]
    else $error("zero fraction stored without true zero");
endmodule
`default_nettype wire

/* File: sim/hfa_seq_model.sv */
// Sequencer model that issues arithmetic requests and collects the completion.
`timescale 1ns/1ps
`default_nettype none
module hfa_seq_model (
  input wire logic sys_clk,
  output logic start,
  output logic [1:0] opCode,
  output logic isDouble,
  output logic [63:0] dstOperand,
  output logic [63:0] srcOperand,
  output logic [31:0] instrAddr,
  input wire logic done,
  input wire logic resultWrite,
  input wire logic [63:0] result
);
  initial begin
    start = 1'b0;
    opCode = 2'b00;
    isDouble = 1'b0;
    dstOperand = 64'h0000_0000_0000_0000;
    srcOperand = 64'h0000_0000_0000_0000;
    instrAddr = 32'h0000_0000;
  end

  // Operands and code stand with a one-cycle start; a poke repeats start while busy with the destination operand inverted.
  task automatic run(input logic [1:0] op, input logic dbl, input logic [63:0] d, input logic [63:0] s,
                     input logic [31:0] a, input logic poke, output logic [63:0] r, output logic w,
                     output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    start <= 1'b1;
    opCode <= op;
    isDouble <= dbl;
    dstOperand <= d;
    srcOperand <= s;
    instrAddr <= a;
    @(posedge sys_clk);
    start <= poke;
    dstOperand <= poke ? ~d : d;
    do begin
      @(posedge sys_clk);
      start <= 1'b0;
      n++;
    end while (done !== 1'b1 && n < 200);
    r = result;
    w = resultWrite;
    ok = (n < 200);
  endtask
endmodule
`default_nettype wire

/* File: sim/hfa_arith_unit_tb_top.sv */
// Self-checking bench for the hex floating-point arithmetic unit.
`timescale 1ns/1ps
`default_nettype none
module hfa_arith_unit_tb_top;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic start, isDouble, busy, done, resultWrite, avs_read, avs_write, avs_waitrequest;
  logic [1:0] opCode;
  logic [63:0] dstOperand, srcOperand, result;
  logic [31:0] instrAddr, avs_writedata, avs_readdata;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hF;
  int bad_count = 0;
  int total_checks = 0;
  localparam logic [31:0] FAULT_PC = 32'h0000_2468;

  initial avs_read = 1'b0;
  initial avs_write = 1'b0;
  initial avs_writedata = 32'h0000_0000;
  always #12.5 sys_clk = ~sys_clk;

  hfa_arith_unit hfa_arith_unit_i (.sys_clk(sys_clk), .nrst(nrst), .start(start), .opCode(opCode),
    .isDouble(isDouble), .dstOperand(dstOperand), .srcOperand(srcOperand), .instrAddr(instrAddr),
    .busy(busy), .done(done), .resultWrite(resultWrite), .result(result), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  hfa_seq_model hfa_seq_model_i (.sys_clk(sys_clk), .start(start), .opCode(opCode), .isDouble(isDouble),
    .dstOperand(dstOperand), .srcOperand(srcOperand), .instrAddr(instrAddr), .done(done),
    .resultWrite(resultWrite), .result(result));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expv);
    total_checks++;
    if (seen !== expv) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // The request is held until waitrequest is sampled low; read data is taken at that same edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) check("bus answer", 64'h0, 64'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] expv);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    check(what, {32'h0, q}, {32'h0, expv});
  endtask

  // Runs one operation and compares the completion, the stored result and its bus copy.
  task automatic op_chk(input logic [1:0] op, input logic dbl, input logic [63:0] d, input logic [63:0] s,
                        input logic [63:0] er, input logic ew, input logic cr);
    logic [63:0] r;
    logic w, ok;
    hfa_seq_model_i.run(op, dbl, d, s, FAULT_PC, 1'b1, r, w, ok);
    check("completion", {63'h0, ok}, 64'h1);
    check("busy at done", {63'h0, busy}, 64'h0);
    check("resultWrite", {63'h0, w}, {63'h0, ew});
    if (ew && cr) begin
      check("result", r, er);
      rd_chk("result hi", hfa_pkg::REG_RESULT_HI, er[63:32]);
      rd_chk("result lo", hfa_pkg::REG_RESULT_LO, er[31:0]);
    end
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk("status reset", hfa_pkg::REG_STATUS, hfa_pkg::STATUS_RESET);
    rd_chk("fault reset", hfa_pkg::REG_FAULT_ADDR, 32'h0000_0000);
    rd_chk("result reset", hfa_pkg::REG_RESULT_HI, 32'h0000_0000);
    wr(4'h2, 32'hFFFF_FFFF, 4'hF);
    rd_chk("unmapped", 4'h2, 32'h0000_0000);
    wr(hfa_pkg::REG_RESULT_HI, 32'hFFFF_FFFF, 4'hF);
    rd_chk("result read only", hfa_pkg::REG_RESULT_HI, 32'h0000_0000);
    wr(hfa_pkg::REG_STATUS, 32'hFFFF_FFFF, 4'h1);
    rd_chk("status byte lane", hfa_pkg::REG_STATUS, 32'h0000_000E);
    wr(hfa_pkg::REG_STATUS, 32'hFFFF_FFFF, 4'hF);
    rd_chk("status mask", hfa_pkg::REG_STATUS, hfa_pkg::STATUS_WMASK);
    wr(hfa_pkg::REG_STATUS, 32'h0000_0000, 4'hF);
    // Truncating mode: one guard digit.
    op_chk(2'b00, 1'b0, 64'h4110_0000_FFFF_FFFF, 64'h4110_0000_0000_0000, 64'h4120_0000_0000_0000, 1, 1);
    op_chk(2'b01, 1'b0, 64'h4110_0000_0000_0000, 64'h4110_0000_0000_0000, 64'h0, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4180_0000_0000_0000, 64'h4180_0000_0000_0000, 64'h4210_0000_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4210_0000_0000_0000, 64'h4110_0000_0000_0000, 64'h4211_0000_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4110_0000_0000_0000, 64'hC130_0000_0000_0000, 64'hC120_0000_0000_0000, 1, 1);
    op_chk(2'b01, 1'b0, 64'h4120_0000_0000_0000, 64'h4130_0000_0000_0000, 64'hC110_0000_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4610_0000_0000_0000, 64'h4180_0000_0000_0000, 64'h4610_0008_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4710_0000_0000_0000, 64'h4180_0000_0000_0000, 64'h4710_0000_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4810_0000_0000_0000, 64'h4110_0000_0000_0000, 64'h4810_0000_0000_0000, 1, 1);
    op_chk(2'b01, 1'b0, 64'h4210_0000_0000_0000, 64'h41F0_0001_0000_0000, 64'h40FF_FFF0_0000_0000, 1, 1);
    op_chk(2'b10, 1'b0, 64'h4120_0000_0000_0000, 64'h4130_0000_0000_0000, 64'h4160_0000_0000_0000, 1, 1);
    op_chk(2'b11, 1'b0, 64'h4160_0000_0000_0000, 64'h4120_0000_0000_0000, 64'h4130_0000_0000_0000, 1, 1);
    op_chk(2'b11, 1'b0, 64'h4110_0000_0000_0000, 64'h4120_0000_0000_0000, 64'h4080_0000_0000_0000, 1, 1);
    op_chk(2'b00, 1'b1, 64'h4110_0000_0000_0001, 64'h4110_0000_0000_0001, 64'h4120_0000_0000_0002, 1, 1);
    // Error paths: flags are sticky, so each is cleared before the next.
    op_chk(2'b11, 1'b0, 64'h4110_0000_0000_0000, 64'h0, 64'h0, 0, 0);
    rd_chk("zero divide status", hfa_pkg::REG_STATUS, 32'h0000_0008);
    rd_chk("fault address", hfa_pkg::REG_FAULT_ADDR, FAULT_PC);
    wr(hfa_pkg::REG_STATUS, 32'h0000_0000, 4'hF);
    op_chk(2'b00, 1'b0, 64'h7F80_0000_0000_0000, 64'h7F80_0000_0000_0000, 64'h0, 0, 0);
    rd_chk("carry overflow", hfa_pkg::REG_STATUS, 32'h0000_0002);
    wr(hfa_pkg::REG_STATUS, 32'h0000_0000, 4'hF);
    op_chk(2'b10, 1'b0, 64'h0110_0000_0000_0000, 64'h0110_0000_0000_0000, 64'h0, 1, 0);
    rd_chk("underflow", hfa_pkg::REG_STATUS, 32'h0000_0004);
    wr(hfa_pkg::REG_STATUS, 32'h0000_0000, 4'hF);
    op_chk(2'b10, 1'b0, 64'h7F10_0000_0000_0000, 64'h7F10_0000_0000_0000, 64'h0, 1, 0);
    rd_chk("overflow", hfa_pkg::REG_STATUS, 32'h0000_0002);
    // Rounding mode: two guard digits.
    wr(hfa_pkg::REG_STATUS, 32'h0000_0100, 4'hF);
    rd_chk("rounding select", hfa_pkg::REG_STATUS, 32'h0000_0100);
    op_chk(2'b00, 1'b0, 64'h4710_0001_0000_0000, 64'h4180_0000_0000_0000, 64'h4710_0002_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4710_0002_0000_0000, 64'h4180_0000_0000_0000, 64'h4710_0002_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4710_0002_0000_0000, 64'h4188_0000_0000_0000, 64'h4710_0003_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4710_0002_0000_0000, 64'h417F_0000_0000_0000, 64'h4710_0002_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h47FF_FFFF_0000_0000, 64'h4188_0000_0000_0000, 64'h4810_0000_0000_0000, 1, 1);
    op_chk(2'b00, 1'b0, 64'h4910_0000_0000_0000, 64'h4110_0000_0000_0000, 64'h4910_0000_0000_0000, 1, 1);
    op_chk(2'b00, 1'b1, 64'h4F10_0000_0000_0001, 64'h4180_0000_0000_0000, 64'h4F10_0000_0000_0002, 1, 1);
    test_done();
  end
endmodule
`default_nettype wire
